// file: shared/smc_map.svh
/*
  Timing counts and field positions for the sleep-mode controller.
  Assumes inclusion by bare name from the controller package user.
*/
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// ----------------------------------------------------------------
// Sleep select encodings
// ----------------------------------------------------------------
`define SMC_SEL_IDLE     3'h0
`define SMC_SEL_ADCNR    3'h1
`define SMC_SEL_PDOWN    3'h2
`define SMC_SEL_PSAVE    3'h3
`define SMC_SEL_STANDBY  3'h6
`define SMC_SEL_XSTANDBY 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMC_CLK_NS       25
`define SMC_HALT_CYC     3'h4
`define SMC_STBY_CYC     16'h0006
`define SMC_BOD_WAKE_NS  60000
`define SMC_BOD_WAKE_CYC ((`SMC_BOD_WAKE_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)

// ----------------------------------------------------------------
// Control register field
// ----------------------------------------------------------------
`define SMC_BROWNOUT_SLEEP_OFF_BIT     6

`endif

// file: shared/smc_pkg.sv
/*
  Types for the sleep-mode controller.
  Assumes the map header is on the include path.
*/
package smc_pkg;
  // Controller sequencing states.
  typedef enum logic [2:0] {
    SMC_RUN   = 3'b000,
    SMC_SLEEP = 3'b001,
    SMC_START = 3'b010,
    SMC_HALT  = 3'b011,
    SMC_RESET = 3'b100
  } smc_state_e;
endpackage

// file: testbench/smc_sleep_ctrl_sva.sv
/*
  Checker for the sleep-mode controller: clock gating, entry and wake timing.
  Assumes it is bound to the controller and sees only its ports.
*/
`timescale 1ns/1ps
module smc_sleep_ctrl_sva (
  // Clock, reset and control.
  input wire logic       CORE_CLK_I,
  input wire logic       RST_I,
  input wire logic       SLEEP_EXEC_I,
  input wire logic       SLEEP_ARM_I,
  input wire logic [2:0] SLEEP_SELECT_I,
  input wire logic       BROWNOUT_SLEEP_OFF_I,
  input wire logic       ADC_ENABLE_I,
  input wire logic       ASYNC_TIMER_EN_I,
  input wire logic       ASYNC_TIMER_ON_SYNC_CLK_I,
  // Watched outputs.
  input wire logic       CPU_CLOCK_EN_O,
  input wire logic       FLASH_CLOCK_EN_O,
  input wire logic       IO_CLOCK_EN_O,
  input wire logic       ADC_CLOCK_EN_O,
  input wire logic       MAIN_OSC_EN_O,
  input wire logic       CORE_HALT_O,
  input wire logic       TAKE_IRQ_O,
  input wire logic       RESET_VECTOR_O,
  input wire logic       ADC_START_O,
  input wire logic       BROWNOUT_DETECTOR_EN_O,
  input wire logic       ASLEEP_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Deep modes: everything from power-down upward, where the detector may be off.
  logic deep;
  assign deep = SLEEP_SELECT_I[2] | SLEEP_SELECT_I[1];

  a_sleep_entry: assert property (SLEEP_EXEC_I && SLEEP_ARM_I && !CORE_HALT_O |=> ASLEEP_O && !CPU_CLOCK_EN_O)
    else $error("armed sleep did not gate the core");
  a_unarmed_noop: assert property (SLEEP_EXEC_I && !SLEEP_ARM_I && !CORE_HALT_O |=> !ASLEEP_O && CPU_CLOCK_EN_O)
    else $error("unarmed sleep changed state");
  a_idle_clocks: assert property (ASLEEP_O && SLEEP_SELECT_I == 3'h0
    |-> !CPU_CLOCK_EN_O && !FLASH_CLOCK_EN_O && IO_CLOCK_EN_O && ADC_CLOCK_EN_O)
    else $error("idle gating wrong");
  a_noise_clocks: assert property (ASLEEP_O && SLEEP_SELECT_I == 3'h1
    |-> !IO_CLOCK_EN_O && !FLASH_CLOCK_EN_O && ADC_CLOCK_EN_O)
    else $error("noise reduction gating wrong");
  // Power-save keeps the main source only to feed a synchronously clocked timer.
  a_deep_clocks: assert property (ASLEEP_O && SLEEP_SELECT_I[2:1] == 2'h1
    |-> !IO_CLOCK_EN_O && !ADC_CLOCK_EN_O
        && MAIN_OSC_EN_O == (SLEEP_SELECT_I[0] && ASYNC_TIMER_EN_I && ASYNC_TIMER_ON_SYNC_CLK_I))
    else $error("power-down gating wrong");
  a_standby_osc: assert property (ASLEEP_O && SLEEP_SELECT_I[2:1] == 2'h3 |-> MAIN_OSC_EN_O && !CPU_CLOCK_EN_O)
    else $error("standby oscillator stopped");
  a_adc_autostart: assert property ($rose(ASLEEP_O) && ADC_ENABLE_I && !deep |-> ADC_START_O)
    else $error("no conversion start on entry");
  a_bod_kept: assert property (!(ASLEEP_O && deep) |-> BROWNOUT_DETECTOR_EN_O)
    else $error("detector off outside deep sleep");
  a_bod_off: assert property (ASLEEP_O && deep && BROWNOUT_SLEEP_OFF_I |-> !BROWNOUT_DETECTOR_EN_O)
    else $error("detector left on in sleep");
  a_halt_four: assert property ($rose(TAKE_IRQ_O) |-> $past(CORE_HALT_O, 4) && !$past(ASLEEP_O, 4))
    else $error("halt cycles before interrupt wrong");
  a_reset_vec: assert property ($rose(RESET_VECTOR_O) |-> !CORE_HALT_O && $past(CORE_HALT_O))
    else $error("reset vector outside wake");

  c_irq_wake: cover property ($rose(TAKE_IRQ_O));
  c_rst_wake: cover property ($rose(RESET_VECTOR_O));
  c_bod_off: cover property (ASLEEP_O && !BROWNOUT_DETECTOR_EN_O);
endmodule

// file: testbench/smc_sleep_ctrl_tb_top.sv
/*
  Bench for the sleep-mode controller: hand-picked and random sleep trials.
  Assumes the wake model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module smc_sleep_ctrl_tb_top;
  logic CORE_CLK_I = 1'h0, RST_I = 1'h1, SLEEP_EXEC_I = 1'h0, SLEEP_ARM_I = 1'h0;
  logic BROWNOUT_SLEEP_OFF_I = 1'h0, GLOBAL_IRQ_EN_I = 1'h0, ADC_ENABLE_I = 1'h0;
  logic ASYNC_TIMER_EN_I = 1'h0, ASYNC_TIMER_ON_ASYNC_CLK_I = 1'h0, ASYNC_TIMER_ON_SYNC_CLK_I = 1'h0;
  logic [2:0]  SLEEP_SELECT_I = 3'h0;
  logic [1:0]  ASYNC_TIMER_IRQ_MASK_I = 2'h0;
  logic [15:0] STARTUP_CYCLES_I = 16'h0003;
  wire  ANY_ENABLED_IRQ_I, ADC_DONE_IRQ_I, EXT_RESET_I, WDOG_RESET_I, WDOG_IRQ_I, BROWNOUT_RESET_I;
  wire  TWO_WIRE_MATCH_I, STORE_READY_IRQ_I, EXT_LEVEL_IRQ_I, PIN_CHANGE_IRQ_I, SERIAL_SOF_I;
  wire  [1:0]  ASYNC_TIMER_EVT_I;
  wire  [12:0] wk;
  logic CPU_CLOCK_EN_O, FLASH_CLOCK_EN_O, IO_CLOCK_EN_O, ADC_CLOCK_EN_O, ASYNC_CLOCK_EN_O;
  logic MAIN_OSC_EN_O, TIMER_OSC_EN_O, CORE_HALT_O, TAKE_IRQ_O, RESET_VECTOR_O;
  logic ADC_START_O, BROWNOUT_DETECTOR_EN_O, ASLEEP_O;
  logic go = 1'h0;
  logic [3:0] src = 4'h0;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  int   error_cnt = 0, checks_done = 0, cyc = 0;
  // Source index order matches the model's one-hot bits.
  assign {SERIAL_SOF_I, PIN_CHANGE_IRQ_I, EXT_LEVEL_IRQ_I, STORE_READY_IRQ_I, ASYNC_TIMER_EVT_I,
          TWO_WIRE_MATCH_I, BROWNOUT_RESET_I, WDOG_IRQ_I, WDOG_RESET_I, EXT_RESET_I,
          ADC_DONE_IRQ_I, ANY_ENABLED_IRQ_I} = wk;

  always #12.5 CORE_CLK_I = ~CORE_CLK_I;
  smc_sleep_ctrl u_smc_sleep_ctrl (.*);
  smc_wake_model u_smc_wake_model (.clk_i(CORE_CLK_I), .halt_i(CORE_HALT_O), .go_i(go), .src_i(src), .wake_o(wk));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Which sources may end each mode; idle and noise reduction use a safe subset.
  function automatic bit ok_wake(input logic [2:0] s, input logic [3:0] k);
    if (k inside {2, 3, 5, 10}) return 1'b1;
    if (s == 3'h0) return k == 0;
    if (s == 3'h1) return k != 0;
    if (k inside {7, 8}) return s[0] && GLOBAL_IRQ_EN_I && ASYNC_TIMER_IRQ_MASK_I[k-7];
    return k inside {4, 6, 11, 12};
  endfunction
  // Falling edges from the request to the first running cycle.
  function automatic int exp_cyc(input logic [2:0] s, input logic [3:0] k);
    int n;
    n = (s <= 3'h1) ? 1 : (s >= 3'h6) ? 6 : (STARTUP_CYCLES_I == 0) ? 1 : int'(STARTUP_CYCLES_I);
    if (BROWNOUT_SLEEP_OFF_I && s >= 3'h2 && n < 2400) n = 2400;
    return (k inside {2, 3, 5}) ? 3 : n + 6;
  endfunction
  task automatic wake(input logic [3:0] k, input int e, input logic rv);
    int n;
    src = k;
    go = 1'h1;
    for (n = 1; n < 2700; n++) begin
      @(negedge CORE_CLK_I) go = 1'h0;
      if (TAKE_IRQ_O === 1'b1 || RESET_VECTOR_O === 1'b1) break;
    end
    chk("wake_cycles", n, e);
    chk("reset_vector", RESET_VECTOR_O, rv);
  endtask
  task automatic trial(input logic [2:0] s, input logic [3:0] k);
    logic tmr;
    @(negedge CORE_CLK_I);
    SLEEP_SELECT_I = s;
    SLEEP_ARM_I = 1'h1;
    SLEEP_EXEC_I = 1'h1;
    @(negedge CORE_CLK_I);
    SLEEP_EXEC_I = 1'h0;
    // Past noise reduction, the async timer keeps its clock only in the power-save style modes.
    tmr = ASYNC_TIMER_EN_I && s[0] && s >= 2;
    chk("asleep", ASLEEP_O, 1);
    chk("cpu_clk", CPU_CLOCK_EN_O, 0);
    chk("io_clk", IO_CLOCK_EN_O, s == 0);
    chk("adc_clk", ADC_CLOCK_EN_O, s <= 1);
    chk("main_osc", MAIN_OSC_EN_O, s <= 1 || s >= 6 || (s == 3 && tmr && ASYNC_TIMER_ON_SYNC_CLK_I));
    chk("async_clk", ASYNC_CLOCK_EN_O, s <= 1 || tmr);
    chk("timer_osc", TIMER_OSC_EN_O, ASYNC_TIMER_ON_ASYNC_CLK_I && (s <= 1 || tmr));
    chk("adc_start", ADC_START_O, ADC_ENABLE_I && s <= 1);
    chk("bod_en", BROWNOUT_DETECTOR_EN_O, !(BROWNOUT_SLEEP_OFF_I && s >= 2));
    // A refused source must leave the core asleep; a reset then ends the trial.
    if (!ok_wake(s, k)) begin
      src = k;
      go = 1'h1;
      @(negedge CORE_CLK_I) go = 1'h0;
      repeat (11) @(negedge CORE_CLK_I);
      chk("refused", ASLEEP_O, 1);
      k = 4'h2;
    end
    wake(k, exp_cyc(s, k), k inside {2, 3, 5});
    $display("trial mode %0d source %0d done", s, k);
  endtask

  always @(posedge CORE_CLK_I) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    logic [3:0] k;
    logic [2:0] s;
    void'($urandom(32'h3cb74f0f));
    repeat (5) @(posedge CORE_CLK_I);
    @(negedge CORE_CLK_I);
    RST_I = 1'h0;
    chk("reset_bod", BROWNOUT_DETECTOR_EN_O, 1);
    SLEEP_EXEC_I = 1'h1;
    @(negedge CORE_CLK_I);
    SLEEP_EXEC_I = 1'h0;
    chk("noop", ASLEEP_O, 0);
    chk("noop_cpu", CPU_CLOCK_EN_O, 1);
    $display("unarmed sleep test done");
    foreach (modes[i]) trial(modes[i], (modes[i] == 3'h0) ? 4'ha : 4'hb);
    trial(3'h2, 4'hc);
    trial(3'h3, 4'h3);
    trial(3'h2, 4'h1);
    // The bit arrives here as if already written through its timed sequence.
    BROWNOUT_SLEEP_OFF_I = 1'h1;
    trial(3'h2, 4'hb);
    trial(3'h6, 4'h6);
    {BROWNOUT_SLEEP_OFF_I, GLOBAL_IRQ_EN_I, ASYNC_TIMER_EN_I, ASYNC_TIMER_IRQ_MASK_I} = 5'h0f;
    trial(3'h3, 4'h7);
    ASYNC_TIMER_IRQ_MASK_I = 2'h1;
    trial(3'h3, 4'h8);
    repeat (30) begin
      s = modes[$urandom_range(0, 5)];
      k = 4'($urandom_range(0, 12));
      if (s == 3'h0 && !(k inside {0, 2, 3, 5, 10})) k = 4'h0;
      if (s == 3'h1 && k inside {7, 8, 12}) k = 4'h1;
      {BROWNOUT_SLEEP_OFF_I, GLOBAL_IRQ_EN_I, ADC_ENABLE_I, ASYNC_TIMER_IRQ_MASK_I} = 5'($urandom);
      {ASYNC_TIMER_EN_I, ASYNC_TIMER_ON_ASYNC_CLK_I, ASYNC_TIMER_ON_SYNC_CLK_I} = 3'($urandom);
      if (k inside {7, 8}) {ASYNC_TIMER_EN_I, ASYNC_TIMER_ON_ASYNC_CLK_I} = 2'h3;
      STARTUP_CYCLES_I = 16'($urandom_range(0, 40));
      trial(s, k);
    end
    close_out();
  end
endmodule

bind smc_sleep_ctrl smc_sleep_ctrl_sva u_smc_sleep_ctrl_sva (.*);

// file: testbench/smc_wake_model.sv
/*
  Wake sources beside the core: raises one source on request.
  Assumes requests arrive off the rising edge of the core clock.
*/
`timescale 1ns/1ps
module smc_wake_model (
  // Clock and core state.
  input  wire logic        clk_i,
  input  wire logic        halt_i,
  // Bench request: binary source index, decoded to a one-hot level.
  input  wire logic        go_i,
  input  wire logic [3:0]  src_i,
  // Wake source levels, active high.
  output logic      [12:0] wake_o
);
  logic [12:0] wake_reg;
  logic [12:0] wake_next;
  // A source is held until the core runs, so a level outlasts start-up.
  always_comb begin
    wake_next = halt_i ? wake_reg : 13'h0000;
    if (go_i) begin
      wake_next = 13'h0001 << src_i;
    end
  end
  always_ff @(posedge clk_i) begin
    wake_reg <= wake_next;
  end
  assign wake_o = wake_reg;
endmodule

// file: verilog/smc_sleep_ctrl.sv
/*
  Sleep-mode controller: gates clock domains on a sleep instruction, selects
  wake sources by mode and sequences start-up, halt and interrupt entry.
  Assumes all inputs synchronous to CORE_CLK_I and that the timed write of
  the brown-out sleep bit is done outside this block.
*/
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int STARTUP_W = 16
) (
  // Clock and reset.
  input  wire logic                 CORE_CLK_I,
  input  wire logic                 RST_I,
  // Core and software control.
  input  wire logic                 SLEEP_EXEC_I,
  input  wire logic                 SLEEP_ARM_I,
  input  wire logic [2:0]           SLEEP_SELECT_I,
  input  wire logic                 BROWNOUT_SLEEP_OFF_I,
  input  wire logic                 GLOBAL_IRQ_EN_I,
  input  wire logic [STARTUP_W-1:0] STARTUP_CYCLES_I,
  // Configuration of peripherals.
  input  wire logic                 ADC_ENABLE_I,
  input  wire logic                 ASYNC_TIMER_EN_I,
  input  wire logic                 ASYNC_TIMER_ON_ASYNC_CLK_I,
  input  wire logic                 ASYNC_TIMER_ON_SYNC_CLK_I,
  input  wire logic [1:0]           ASYNC_TIMER_IRQ_MASK_I,
  // Wake sources.
  input  wire logic                 ANY_ENABLED_IRQ_I,
  input  wire logic                 ADC_DONE_IRQ_I,
  input  wire logic                 EXT_RESET_I,
  input  wire logic                 WDOG_RESET_I,
  input  wire logic                 WDOG_IRQ_I,
  input  wire logic                 BROWNOUT_RESET_I,
  input  wire logic                 TWO_WIRE_MATCH_I,
  input  wire logic [1:0]           ASYNC_TIMER_EVT_I,
  input  wire logic                 STORE_READY_IRQ_I,
  input  wire logic                 EXT_LEVEL_IRQ_I,
  input  wire logic                 PIN_CHANGE_IRQ_I,
  input  wire logic                 SERIAL_SOF_I,
  // Clock domain enables.
  output logic                      CPU_CLOCK_EN_O,
  output logic                      FLASH_CLOCK_EN_O,
  output logic                      IO_CLOCK_EN_O,
  output logic                      ADC_CLOCK_EN_O,
  output logic                      ASYNC_CLOCK_EN_O,
  output logic                      MAIN_OSC_EN_O,
  output logic                      TIMER_OSC_EN_O,
  // Core sequencing and side effects.
  output logic                      CORE_HALT_O,
  output logic                      TAKE_IRQ_O,
  output logic                      RESET_VECTOR_O,
  output logic                      ADC_START_O,
  output logic                      BROWNOUT_DETECTOR_EN_O,
  output logic                      ASLEEP_O
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [STARTUP_W-1:0] BOD_CYC = STARTUP_W'(`SMC_BOD_WAKE_CYC);
  localparam logic [STARTUP_W-1:0] STB_CYC = STARTUP_W'(`SMC_STBY_CYC);

  smc_state_e             state_reg, state_next;      // Sequencer state.
  logic [2:0]             mode_reg, mode_next;        // Mode latched at entry.
  logic                   brownout_sleep_off_reg, brownout_sleep_off_next;        // Detector turned off this sleep.
  logic                   irq_reg, irq_next;          // Wake came from interrupt.
  logic [STARTUP_W-1:0]   cnt_reg, cnt_next;          // Start-up and halt counter.
  logic                   adc_reg, adc_next;          // Conversion start pulse.
  logic                   take_reg, take_next;        // Interrupt entry pulse.
  logic                   rvec_reg, rvec_next;        // Reset-vector pulse.
  logic                   any_reset;                  // Any reset source.
  logic                   wake_irq;                   // Wake by interrupt in mode.
  logic                   timer_wake;                 // Async timer wake qualified.
  logic                   deep;                       // Any mode beyond idle.
  logic                   bod_capable;                // Mode supports detector off.

  // ----------------------------------------------------------------
  // Wake decode
  // ----------------------------------------------------------------
  // Resets wake from every mode; they never take the interrupt path.
  assign any_reset   = EXT_RESET_I | WDOG_RESET_I | BROWNOUT_RESET_I;
  assign deep        = (mode_reg != `SMC_SEL_IDLE);
  assign timer_wake  = ASYNC_TIMER_EN_I & GLOBAL_IRQ_EN_I
                       & |(ASYNC_TIMER_EVT_I & ASYNC_TIMER_IRQ_MASK_I);
  assign bod_capable = deep && (mode_reg != `SMC_SEL_ADCNR);

  // Per-mode interrupt wake sources; serial only wakes via start-of-frame.
  always_comb begin
    wake_irq = 1'b0;
    if (mode_reg == `SMC_SEL_IDLE) begin
      // An external level interrupt is an enabled interrupt as well, so it wakes idle too.
      wake_irq = ANY_ENABLED_IRQ_I | EXT_LEVEL_IRQ_I;
    end else if (mode_reg == `SMC_SEL_ADCNR) begin
      wake_irq = ADC_DONE_IRQ_I | WDOG_IRQ_I | TWO_WIRE_MATCH_I | timer_wake
                 | STORE_READY_IRQ_I | EXT_LEVEL_IRQ_I | PIN_CHANGE_IRQ_I | SERIAL_SOF_I;
    end else if (mode_reg == `SMC_SEL_PSAVE || mode_reg == `SMC_SEL_XSTANDBY) begin
      wake_irq = WDOG_IRQ_I | TWO_WIRE_MATCH_I | EXT_LEVEL_IRQ_I | PIN_CHANGE_IRQ_I
                 | SERIAL_SOF_I | timer_wake;
    end else begin
      wake_irq = WDOG_IRQ_I | TWO_WIRE_MATCH_I | EXT_LEVEL_IRQ_I | PIN_CHANGE_IRQ_I
                 | SERIAL_SOF_I;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // The sequencer gates clocks, holds the core, starts conversions and switches the detector; it never touches
  // core storage, so register file and data memory survive a wake.
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    brownout_sleep_off_next  = brownout_sleep_off_reg;
    irq_next   = irq_reg;
    cnt_next   = cnt_reg;
    adc_next   = 1'b0;
    take_next  = 1'b0;
    rvec_next  = 1'b0;
    case (state_reg)
      SMC_RUN: begin
        // Unarmed sleep falls through as a no-op.
        if (SLEEP_EXEC_I && SLEEP_ARM_I) begin
          state_next = SMC_SLEEP;
          mode_next  = SLEEP_SELECT_I;
          brownout_sleep_off_next  = BROWNOUT_SLEEP_OFF_I && SLEEP_SELECT_I != `SMC_SEL_IDLE
                       && SLEEP_SELECT_I != `SMC_SEL_ADCNR;
          adc_next   = ADC_ENABLE_I && (SLEEP_SELECT_I == `SMC_SEL_IDLE
                       || SLEEP_SELECT_I == `SMC_SEL_ADCNR);
        end
      end
      SMC_SLEEP: begin
        if (any_reset) begin
          state_next = SMC_RESET;
        end else if (wake_irq) begin
          irq_next   = 1'b1;
          state_next = SMC_START;
          // Standby keeps the oscillator, so the short wake applies unless the detector was off.
          if (mode_reg == `SMC_SEL_STANDBY || mode_reg == `SMC_SEL_XSTANDBY) begin
            cnt_next = STB_CYC;
          end else if (mode_reg == `SMC_SEL_IDLE || mode_reg == `SMC_SEL_ADCNR) begin
            cnt_next = STARTUP_W'(1);
          end else begin
            cnt_next = STARTUP_CYCLES_I;
          end
          // A detector that was off stretches the wake to its settling time.
          if (brownout_sleep_off_reg && cnt_next < BOD_CYC) begin
            cnt_next = BOD_CYC;
          end
        end
      end
      SMC_START: begin
        if (any_reset) begin
          state_next = SMC_RESET;
        end else if (cnt_reg <= STARTUP_W'(1)) begin
          state_next = SMC_HALT;
          cnt_next   = STARTUP_W'(`SMC_HALT_CYC);
          brownout_sleep_off_next  = 1'b0;
        end else begin
          cnt_next = cnt_reg - STARTUP_W'(1);
        end
      end
      SMC_HALT: begin
        if (cnt_reg <= STARTUP_W'(1)) begin
          state_next = SMC_RUN;
          // In idle, a level interrupt gone before the halt count ends gives wake but no entry.
          take_next  = irq_reg & (ANY_ENABLED_IRQ_I | EXT_LEVEL_IRQ_I | deep);
          irq_next   = 1'b0;
        end else begin
          cnt_next = cnt_reg - STARTUP_W'(1);
        end
      end
      SMC_RESET: begin
        state_next = SMC_RUN;
        rvec_next  = 1'b1;
        brownout_sleep_off_next  = 1'b0;
        irq_next   = 1'b0;
      end
      default: begin
        state_next = SMC_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_reg <= SMC_RUN;
      mode_reg  <= `SMC_SEL_IDLE;
      brownout_sleep_off_reg  <= 1'b0;
      irq_reg   <= 1'b0;
      cnt_reg   <= '0;
      adc_reg   <= 1'b0;
      take_reg  <= 1'b0;
      rvec_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      brownout_sleep_off_reg  <= brownout_sleep_off_next;
      irq_reg   <= irq_next;
      cnt_reg   <= cnt_next;
      adc_reg   <= adc_next;
      take_reg  <= take_next;
      rvec_reg  <= rvec_next;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating outputs
  // ----------------------------------------------------------------
  // Clocks follow the latched mode while asleep; during start-up the
  // oscillator runs but the core is still held, which keeps it safe.
  always_comb begin
    CPU_CLOCK_EN_O   = (state_reg == SMC_RUN);
    FLASH_CLOCK_EN_O = (state_reg == SMC_RUN);
    IO_CLOCK_EN_O    = 1'b1;
    ADC_CLOCK_EN_O   = 1'b1;
    ASYNC_CLOCK_EN_O = 1'b1;
    MAIN_OSC_EN_O    = 1'b1;
    TIMER_OSC_EN_O   = ASYNC_TIMER_ON_ASYNC_CLK_I;
    if (state_reg == SMC_SLEEP) begin
      if (mode_reg == `SMC_SEL_IDLE) begin
        IO_CLOCK_EN_O = 1'b1;
      end else if (mode_reg == `SMC_SEL_ADCNR) begin
        IO_CLOCK_EN_O = 1'b0;
      end else begin
        IO_CLOCK_EN_O    = 1'b0;
        ADC_CLOCK_EN_O   = 1'b0;
        // Power-save style modes keep the timer clock only when used.
        ASYNC_CLOCK_EN_O = (mode_reg == `SMC_SEL_PSAVE || mode_reg == `SMC_SEL_XSTANDBY)
                           && ASYNC_TIMER_EN_I;
        TIMER_OSC_EN_O   = ASYNC_CLOCK_EN_O && ASYNC_TIMER_ON_ASYNC_CLK_I;
        MAIN_OSC_EN_O    = (mode_reg == `SMC_SEL_STANDBY || mode_reg == `SMC_SEL_XSTANDBY)
                           || (mode_reg == `SMC_SEL_PSAVE && ASYNC_TIMER_EN_I
                           && ASYNC_TIMER_ON_SYNC_CLK_I);
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and pulse outputs
  // ----------------------------------------------------------------
  assign CORE_HALT_O            = (state_reg != SMC_RUN);
  assign TAKE_IRQ_O             = take_reg;
  assign RESET_VECTOR_O         = rvec_reg;
  assign ADC_START_O            = adc_reg;
  assign BROWNOUT_DETECTOR_EN_O = !(brownout_sleep_off_reg && state_reg == SMC_SLEEP && bod_capable);
  assign ASLEEP_O               = (state_reg == SMC_SLEEP);

endmodule
